// ===== ptr_regs.svh
// Purpose: register offsets, field positions, reset values and base clock rate of the timer
// Assumes: byte registers on a 32-bit apb, printed offsets are register indices
// Notes: byte address is four times the index
`ifndef PTR_REGS_SVH
`define PTR_REGS_SVH

// ***************************************************************
// register indices
// ***************************************************************
`define PTR_IDX_MODE        6'h2a
`define PTR_IDX_PRESC_LO    6'h2b
`define PTR_IDX_RELOAD_HI   6'h2c
`define PTR_IDX_RELOAD_LO   6'h2d
`define PTR_IDX_COUNT_HI    6'h2e
`define PTR_IDX_COUNT_LO    6'h2f
`define PTR_IDX_CONTROL     6'h38
`define PTR_IDX_IRQ_STATUS  6'h39
`define PTR_IDX_IRQ_MASK    6'h3a

// ***************************************************************
// field positions
// ***************************************************************
`define PTR_MODE_AUTO_START    7
`define PTR_MODE_AUTO_RESTART  4
`define PTR_CTL_EVEN_DIV       0
`define PTR_CTL_MULTI_FRAME    1
`define PTR_CTL_START_NOW      6
`define PTR_CTL_STOP_NOW       7
`define PTR_IRQ_EXPIRED        0
`define PTR_IRQ_RUNNING        7

// ***************************************************************
// reset values
// ***************************************************************
`define PTR_RST_BYTE  8'h00

// ***************************************************************
// timing
// ***************************************************************
`define PTR_BASE_CLK_KHZ  13560
`endif

// ===== ptr_pkg.sv
// Purpose: types shared by the timer files
// Assumes: nothing
// Notes: constants live in ptr_regs.svh
package ptr_pkg;
   typedef enum logic [1:0] {
      PTR_IDLE = 2'b00,
      PTR_RUN = 2'b01,
      PTR_DONE = 2'b10
   } ptr_state_t;
endpackage

// ===== ptr_tick_if.sv
// Purpose: prescaler settings and tick between timer modules
// Assumes: single pclk domain
// Notes: tick is a one-cycle enable
`timescale 1ns/1ps
interface ptr_tick_if;
   logic [11:0] prescale_value;
   logic even_divide_select;
   logic run;
   logic tick;
   modport ctl (output prescale_value, output even_divide_select, output run, input tick);
   modport div (input prescale_value, input even_divide_select, input run, output tick);
endinterface

// ===== ptr_prescaler.sv
// Purpose: divides pclk into the timer tick
// Assumes: pclk stands in for the base clock
// Notes: period 2*p+1 or 2*p+2 cycles
`timescale 1ns/1ps
module ptr_prescaler (
   input wire logic pclk,     // clock
   input wire logic presetn,  // async reset, low
   ptr_tick_if.div tk         // settings and tick
);
   logic [12:0] div_count;
   logic [12:0] period_m1;

   // terminal count; restarts from zero whenever the timer is idle
   always_comb begin
      period_m1 = {tk.prescale_value, 1'b0} + {12'h000, tk.even_divide_select};
   end

   // ***************************************************************
   // divider
   // ***************************************************************
   // count 0..period_m1, tick on the last
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 13'h0000;
      end else if (!tk.run || div_count == period_m1) begin
         div_count <= 13'h0000;
      end else begin
         div_count <= div_count + 13'h0001;
      end
   end

   assign tk.tick = tk.run && (div_count == period_m1);
endmodule

// ===== ptr_timer.sv
// Purpose: apb register block and 16-bit down counter of the protocol timer
// Assumes: pclk used as timer base clock; start and stop events are same-domain pulses
// Notes: registers are byte wide, upper 24 bits read zero
//
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "ptr_regs.svh"
module ptr_timer (
   input wire logic pclk,            // clock 40 MHz
   input wire logic presetn,         // async reset, low
   input wire logic psel,            // apb select
   input wire logic penable,         // apb enable
   input wire logic pwrite,          // apb direction
   input wire logic [7:0] paddr,     // apb byte address
   input wire logic [31:0] pwdata,   // apb write data
   output logic [31:0] prdata,       // apb read data
   output logic pready,              // apb ready
   output logic pslverr,             // apb error
   input wire logic tx_end,          // transmission ended pulse
   input wire logic rx_stop_event,   // protocol stop pulse
   output logic timer_running,       // counter active
   output logic irq                  // interrupt level
);
   ptr_tick_if tk ();

   logic [7:0] mode_reg;
   logic [7:0] prescale_low_byte;
   logic [7:0] reload_value_high;
   logic [7:0] reload_value_low;
   logic [7:0] control_reg;
   logic [7:0] irq_status;
   logic [7:0] irq_mask;
   logic [15:0] count;
   ptr_pkg::ptr_state_t state;
   logic wr_en;
   logic rd_en;
   logic [5:0] idx;
   logic idx_ok;
   logic start_event;
   logic stop_event;
   logic expire;
   logic [15:0] reload_value;

   // ***************************************************************
   // apb decode
   // ***************************************************************
   function automatic logic idx_known(input logic [5:0] i);
      if (i == `PTR_IDX_MODE) begin
         return 1'b1;
      end else if (i == `PTR_IDX_PRESC_LO) begin
         return 1'b1;
      end else if (i == `PTR_IDX_RELOAD_HI) begin
         return 1'b1;
      end else if (i == `PTR_IDX_RELOAD_LO) begin
         return 1'b1;
      end else if (i == `PTR_IDX_COUNT_HI) begin
         return 1'b1;
      end else if (i == `PTR_IDX_COUNT_LO) begin
         return 1'b1;
      end else if (i == `PTR_IDX_CONTROL) begin
         return 1'b1;
      end else if (i == `PTR_IDX_IRQ_STATUS) begin
         return 1'b1;
      end else if (i == `PTR_IDX_IRQ_MASK) begin
         return 1'b1;
      end else begin
         return 1'b0;
      end
   endfunction

   // zero-wait slave; unmapped addresses answer with pslverr
   assign idx = paddr[7:2];
   assign idx_ok = idx_known(idx) && (paddr[1:0] == 2'b00);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !idx_ok;
   assign wr_en = psel && penable && pwrite && idx_ok;
   assign rd_en = psel && !penable && !pwrite;

   // ***************************************************************
   // configuration registers
   // ***************************************************************
   // writable bytes; reload bytes reach the counter via start or an auto-restart expiry
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= `PTR_RST_BYTE;
         prescale_low_byte <= `PTR_RST_BYTE;
         reload_value_high <= `PTR_RST_BYTE;
         reload_value_low <= `PTR_RST_BYTE;
         irq_mask <= `PTR_RST_BYTE;
      end else if (wr_en) begin
         if (idx == `PTR_IDX_MODE) begin
            mode_reg <= pwdata[7:0];
         end else if (idx == `PTR_IDX_PRESC_LO) begin
            prescale_low_byte <= pwdata[7:0];
         end else if (idx == `PTR_IDX_RELOAD_HI) begin
            reload_value_high <= pwdata[7:0];
         end else if (idx == `PTR_IDX_RELOAD_LO) begin
            reload_value_low <= pwdata[7:0];
         end else if (idx == `PTR_IDX_IRQ_MASK) begin
            irq_mask <= pwdata[7:0];
         end
      end
   end

   // control: even select and multi-frame persist, start/stop self-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_reg <= `PTR_RST_BYTE;
      end else if (wr_en && idx == `PTR_IDX_CONTROL) begin
         control_reg <= pwdata[7:0];
      end else begin
         control_reg[`PTR_CTL_START_NOW] <= 1'b0;
         control_reg[`PTR_CTL_STOP_NOW] <= 1'b0;
      end
   end

   assign reload_value = {reload_value_high, reload_value_low};
   assign tk.prescale_value = {mode_reg[3:0], prescale_low_byte};
   assign tk.even_divide_select = control_reg[`PTR_CTL_EVEN_DIV];
   assign tk.run = (state == ptr_pkg::PTR_RUN);

   // ***************************************************************
   // events
   // ***************************************************************
   assign start_event = control_reg[`PTR_CTL_START_NOW]
                        || (tx_end && mode_reg[`PTR_MODE_AUTO_START]);
   // protocol stops are ignored in multi-frame receive
   assign stop_event = control_reg[`PTR_CTL_STOP_NOW]
                       || (rx_stop_event && mode_reg[`PTR_MODE_AUTO_START]
                           && !control_reg[`PTR_CTL_MULTI_FRAME]);
   assign expire = tk.run && tk.tick && (count == 16'h0000);

   // ***************************************************************
   // counter
   // ***************************************************************
   // state of the timer; start wins over stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ptr_pkg::PTR_IDLE;
      end else if (start_event) begin
         state <= ptr_pkg::PTR_RUN;
      end else if (stop_event) begin
         state <= ptr_pkg::PTR_IDLE;
      end else begin
         case (state)
            ptr_pkg::PTR_RUN: begin
               if (expire && !mode_reg[`PTR_MODE_AUTO_RESTART]) begin
                  state <= ptr_pkg::PTR_DONE;
               end
            end
            ptr_pkg::PTR_DONE: begin
               state <= ptr_pkg::PTR_IDLE;
            end
            default: begin
               state <= ptr_pkg::PTR_IDLE;
            end
         endcase
      end
   end

   // count value; held when idle so software can read the last count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 16'h0000;
      end else if (start_event) begin
         count <= reload_value;
      end else if (expire && mode_reg[`PTR_MODE_AUTO_RESTART]) begin
         count <= reload_value;
      end else if (tk.run && tk.tick && count != 16'h0000) begin
         count <= count - 16'h0001;
      end
   end

   // ***************************************************************
   // interrupts
   // ***************************************************************
   // sticky status, write one to clear; a new event wins over the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `PTR_RST_BYTE;
      end else begin
         if (wr_en && idx == `PTR_IDX_IRQ_STATUS) begin
            irq_status <= irq_status & ~pwdata[7:0];
         end
         if (expire && !mode_reg[`PTR_MODE_AUTO_RESTART]) begin
            irq_status[`PTR_IRQ_EXPIRED] <= 1'b1;
         end
      end
   end

   // interrupt level from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
      end
   end

   assign timer_running = (state == ptr_pkg::PTR_RUN);

   // ***************************************************************
   // read data
   // ***************************************************************
   // captured in setup phase so prdata comes from a flop in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_en) begin
         if (idx == `PTR_IDX_MODE) begin
            prdata <= {24'h000000, mode_reg};
         end else if (idx == `PTR_IDX_PRESC_LO) begin
            prdata <= {24'h000000, prescale_low_byte};
         end else if (idx == `PTR_IDX_RELOAD_HI) begin
            prdata <= {24'h000000, reload_value_high};
         end else if (idx == `PTR_IDX_RELOAD_LO) begin
            prdata <= {24'h000000, reload_value_low};
         end else if (idx == `PTR_IDX_COUNT_HI) begin
            prdata <= {24'h000000, count[15:8]};
         end else if (idx == `PTR_IDX_COUNT_LO) begin
            prdata <= {24'h000000, count[7:0]};
         end else if (idx == `PTR_IDX_CONTROL) begin
            prdata <= {24'h000000, 6'h00, control_reg[1:0]};
         end else if (idx == `PTR_IDX_IRQ_STATUS) begin
            prdata <= {24'h000000, timer_running, irq_status[6:0]};
         end else if (idx == `PTR_IDX_IRQ_MASK) begin
            prdata <= {24'h000000, irq_mask};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // ***************************************************************
   // prescaler
   // ***************************************************************
   ptr_prescaler u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .tk(tk)
   );
endmodule

// ===== ptr_timer_assertions.sv
// Purpose: port-level checks of the protocol timer
// Assumes: sees only ptr_timer ports, one clock domain
// Notes: mode and control bits are shadowed from apb writes
`timescale 1ns/1ps
`include "ptr_regs.svh"
module ptr_timer_assertions (
   input wire logic pclk, // clock
   input wire logic presetn, // async reset, low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic tx_end, // transmission end
   input wire logic rx_stop_event, // protocol stop
   input wire logic timer_running, // counter active
   input wire logic irq // interrupt level
);
   // ***************************************************************
   // helpers and properties
   // ***************************************************************
   logic [5:0] idx;
   logic acc, wr, mapped, auto_start, auto_rst, multi;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // decode of the access phase
   assign idx = paddr[7:2];
   assign acc = psel && penable;
   assign wr = acc && pwrite && paddr[1:0] == 2'b00;
   assign mapped = (idx >= `PTR_IDX_MODE && idx <= `PTR_IDX_COUNT_LO) ||
      (idx >= `PTR_IDX_CONTROL && idx <= `PTR_IDX_IRQ_MASK);
   // shadow copy, so event rules can see the enables
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         auto_start <= 1'b0;
         auto_rst <= 1'b0;
         multi <= 1'b0;
      end else if (wr && idx == `PTR_IDX_MODE) begin
         auto_start <= pwdata[`PTR_MODE_AUTO_START];
         auto_rst <= pwdata[`PTR_MODE_AUTO_RESTART];
      end else if (wr && idx == `PTR_IDX_CONTROL) begin
         multi <= pwdata[`PTR_CTL_MULTI_FRAME];
      end
   end
   sequence start_wr;
      wr && idx == `PTR_IDX_CONTROL && pwdata[`PTR_CTL_START_NOW];
   endsequence
   sequence stop_wr;
      wr && idx == `PTR_IDX_CONTROL && pwdata[`PTR_CTL_STOP_NOW] && !pwdata[`PTR_CTL_START_NOW];
   endsequence
   a_ready_high: assert property (pready) else $error("pready low");
   a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
   a_misaligned_err: assert property (acc && paddr[1:0] != 2'b00 |-> pslverr)
      else $error("misaligned access not refused");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_mapped_read: assert property (acc && !pwrite && paddr[1:0] == 2'b00 && mapped |-> !pslverr)
      else $error("mapped read refused");
   a_start_runs: assert property (start_wr |-> ##[1:3] timer_running)
      else $error("start write did not run timer");
   a_stop_halts: assert property (stop_wr and !tx_end |-> ##[1:3] !timer_running)
      else $error("stop write did not halt timer");
   a_auto_start: assert property (tx_end && auto_start |-> ##[1:3] timer_running)
      else $error("transmission end did not start timer");
   a_multi_holds: assert property (rx_stop_event && multi && auto_rst && timer_running
      && !wr |=> timer_running)
      else $error("protocol stop halted multi-frame timer");
endmodule

// ===== protocol_timer_prescale_reload_test.sv
// Purpose: self-checking bench for the protocol timer
// Assumes: apb at 40 MHz, byte address four times the index
// Notes: divider period is taken as the run-length step between two reloads
`timescale 1ns/1ps
`include "ptr_regs.svh"
module protocol_timer_prescale_reload_test;
   // ***************************************************************
   // stimulus and checks
   // ***************************************************************
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, tx_end = 1'b0, rx_stop_event = 1'b0;
   logic [7:0] paddr = 8'h00, d;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, timer_running, irq, se;
   int fails = 0, checked = 0, cyc = 0, n0, n1, p, e, rl, i;
   initial forever #12.5 pclk = ~pclk;
   // running-cycle count, differences only so start latency cancels
   always @(posedge pclk) cyc <= cyc + 32'(timer_running);
   ptr_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_end(tx_end), .rx_stop_event(rx_stop_event),
      .timer_running(timer_running), .irq(irq));
   function automatic int period(int p, int ev);
      return 2 * p + 1 + ev;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one transfer; holds the request until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] dat);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, dat};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [5:0] ix, input logic [7:0] dat);
      apb(1'b1, {ix, 2'b00}, dat);
   endtask
   task automatic rd(input logic [5:0] ix, input logic [31:0] exp);
      apb(1'b0, {ix, 2'b00}, 8'h00);
      chk(r, exp);
   endtask
   task automatic pulse(input logic tx);
      if (tx) tx_end <= 1'b1;
      else rx_stop_event <= 1'b1;
      @(posedge pclk);
      tx_end <= 1'b0;
      rx_stop_event <= 1'b0;
      repeat (4) @(posedge pclk);
   endtask
   // start, optionally rewrite the reload mid-run, wait for the end
   task automatic run(input logic [7:0] ctl, input logic poke, output int n);
      int c0;
      c0 = cyc;
      wr(`PTR_IDX_CONTROL, ctl | 8'h40);
      if (poke) wr(`PTR_IDX_RELOAD_HI, 8'h55);
      // running rises one edge after the start write lands, so wait for it first
      for (int k = 0; k < 20 && timer_running !== 1'b1; k++) @(posedge pclk);
      for (int k = 0; k < 9000 && timer_running !== 1'b0; k++) @(posedge pclk);
      @(posedge pclk);
      n = cyc - c0;
   endtask
   task automatic tally_and_finish;
      $display("checked=%0d fails=%0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // watchdog, well above the expected run length
   initial begin
      repeat (90000) @(posedge pclk);
      fails++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h0e1a));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 64; i++) rd(6'(i), 32'h0);
      $display("reset values done");
      for (i = `PTR_IDX_PRESC_LO; i <= `PTR_IDX_RELOAD_LO; i++) begin
         d = 8'($urandom);
         wr(6'(i), d);
         rd(6'(i), {24'h0, d});
      end
      apb(1'b1, {`PTR_IDX_RELOAD_LO, 2'b01}, ~d);
      chk({31'h0, se}, 32'h1);
      rd(`PTR_IDX_RELOAD_LO, {24'h0, d});
      wr(`PTR_IDX_COUNT_HI, 8'hff);
      rd(`PTR_IDX_COUNT_HI, 32'h0);
      $display("register access done");
      for (e = 0; e < 4; e++) begin
         p = (e > 1 ? 256 : 0) + $urandom_range(7);
         rl = $urandom_range(9, 4);
         wr(`PTR_IDX_MODE, 8'(p >> 8));
         wr(`PTR_IDX_PRESC_LO, 8'(p));
         wr(`PTR_IDX_RELOAD_HI, 8'h00);
         wr(`PTR_IDX_RELOAD_LO, 8'(rl));
         run(8'(e & 1), 1'b0, n0);
         rd(`PTR_IDX_COUNT_LO, 32'h0);
         rd(`PTR_IDX_IRQ_STATUS, 32'h1);
         wr(`PTR_IDX_RELOAD_LO, 8'(rl + 1));
         run(8'(e & 1), 1'b1, n1);
         chk(n1 - n0, period(p, e & 1));
      end
      $display("divider and reload done");
      chk({31'h0, irq}, 32'h0);
      wr(`PTR_IDX_IRQ_MASK, 8'h01);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h1);
      wr(`PTR_IDX_IRQ_STATUS, 8'h01);
      @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
      $display("interrupt done");
      wr(`PTR_IDX_MODE, 8'h90);
      wr(`PTR_IDX_PRESC_LO, 8'h00);
      // short reload so the 30-cycle wait spans several expiries
      wr(`PTR_IDX_RELOAD_HI, 8'h00);
      wr(`PTR_IDX_RELOAD_LO, 8'h03);
      wr(`PTR_IDX_CONTROL, 8'h02);
      pulse(1'b1);
      repeat (30) @(posedge pclk);
      chk({31'h0, timer_running}, 32'h1);
      pulse(1'b0);
      chk({31'h0, timer_running}, 32'h1);
      wr(`PTR_IDX_CONTROL, 8'h80);
      // the stop lands at the edge the write task returns on
      @(posedge pclk);
      chk({31'h0, timer_running}, 32'h0);
      pulse(1'b1);
      chk({31'h0, timer_running}, 32'h1);
      pulse(1'b0);
      chk({31'h0, timer_running}, 32'h0);
      $display("auto modes done");
      tally_and_finish();
   end
endmodule
bind ptr_timer ptr_timer_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tx_end(tx_end), .rx_stop_event(rx_stop_event),
   .timer_running(timer_running), .irq(irq));
